// *** logic/midi_router_regs.vh ***
`ifndef MIDI_ROUTER_REGS_VH
`define MIDI_ROUTER_REGS_VH
// ==========================================================================
// Register offsets (word index on the register port).
`define REG_CONFIG      4'h0
`define REG_SWITCHES    4'h1
`define REG_MAP_PTR     4'h2
`define REG_MAP_DATA    4'h3
`define REG_SCENE_SEND  4'h4
`define REG_CC_SEND     4'h5
`define REG_SYSEX_SEND  4'h6
`define REG_STATUS      4'h7
// ==========================================================================
// Configuration fields and reset values.
`define PORT_MIDI       2'h0
`define PORT_HOST_A     2'h1
`define PORT_HOST_B     2'h2
`define PORT_HOST_C     2'h3
`define CONFIG_RESET    16'h0000
`define SW_PC_TX        0
`define SW_PC_RX        1
`define SW_PC_OMNI      2
`define SW_PC_ECHO      3
`define SW_CC_TX        4
`define SW_CC_RX        5
`define SW_CC_OMNI      6
`define SW_CC_ECHO      7
`define SW_PM_TX        8
`define SW_PM_RX        9
`define SW_PM_ECHO      10
`define SW_BULK_EN      11
`define SWITCHES_RESET  12'ha03
`define SEND_SUBST_BIT  8
`define SEND_ANSWER_BIT 9
`define SEND_BULK_BIT   10
`define MAP_INIT_BIT    15
`define MAP_INIT_COUNT  7'h63
// ==========================================================================
// Message codes.
`define MSG_PROG        4'hc
`define MSG_CTRL        4'hb
`define MSG_SYSEX       8'hf0
`define MSG_EOX         8'hf7
`define MSG_REALTIME    8'hf8
`define SUB_BULK_DUMP   4'h0
`define SUB_PARAM       4'h1
`define SUB_BULK_REQ    4'h2
`define SUB_PARAM_REQ   4'h3
`define SCENE_RECALL_CODE 8'h10
// ==========================================================================
// Timing: clock in kHz, link rates in units of 10 bit/s.
`define CLK_KHZ         10000
`define MIDI_RATE_X100  3125
`define HOSTB_RATE_X100 3840
`define MIDI_BIT_CYC    ((`CLK_KHZ * 100) / `MIDI_RATE_X100)
`define HOSTB_BIT_CYC   ((`CLK_KHZ * 100) / `HOSTB_RATE_X100)
`endif

// *** logic/midi_message_filter_router.v ***
// Local design decisions: strobed register access and the register offsets.
`include "midi_router_regs.vh"

module midi_message_filter_router #(
	parameter             FIFO_AW  = 4,
	parameter       [7:0] MAKER_ID = 8'h7d // Arbitrary value.
)(
	// Clock and reset.
	input  wire        ref_clk,
	input  wire        rst,
	// Register port.
	input  wire [3:0]  addr,
	input  wire [15:0] wrData,
	input  wire        wrEn,
	input  wire        rdEn,
	output wire [15:0] rdData,
	// Serial pins.
	input  wire        midiIn,
	output wire        midiOut,
	output wire        midiThru,
	input  wire        hostRxd,
	output wire        hostTxd,
	// Mixer side.
	output wire        sceneRecall,
	output wire [6:0]  sceneNum,
	output wire        paramAdjust,
	output wire [6:0]  ccNum,
	output wire [6:0]  ccValue,
	output wire        sysexValid,
	output wire [7:0]  sysexByte,
	output wire        bulkValid,
	output wire [7:0]  bulkByte,
	output wire        paramRequest,
	output wire        bulkRequest,
	output wire [3:0]  requestChannel
);
	localparam integer MIDI_CYC_N  = `MIDI_BIT_CYC;
	localparam integer HOSTB_CYC_N = `HOSTB_BIT_CYC;
	// Bit times fit nine bits at this clock; cut on purpose from the integer counts.
	localparam [8:0] MIDI_CYC  = MIDI_CYC_N[8:0];
	localparam [8:0] HOSTB_CYC = HOSTB_CYC_N[8:0];
	localparam [FIFO_AW:0] DEPTH = {1'b1, {FIFO_AW{1'b0}}};

	// A channel message is taken on the receive channel or anywhere with omni.
	function chanOk;
		input       omni;
		input [3:0] ch;
		input [3:0] want;
		begin
			chanOk = omni | (ch == want);
		end
	endfunction

	reg  [1:0]  portSel_q;
	reg  [3:0]  txCh_q, rxCh_q, reqCh_q;
	reg  [11:0] sw_q;
	reg  [6:0]  mapPtr_q;
	reg  [7:0]  progMap [0:127];
	reg         initBusy_q;
	reg  [6:0]  initIdx_q;
	reg         rdEn_q;
	reg  [15:0] rdData_q;
	reg         midiThru_q, midiOut_q, hostTxd_q;
	reg         sceneRecall_q, paramAdjust_q, sysexValid_q, bulkValid_q;
	reg         paramRequest_q, bulkRequest_q;
	reg  [6:0]  sceneNum_q, ccNum_q, ccValue_q;
	reg  [7:0]  sysexByte_q, bulkByte_q;
	integer     i;

	// ======================================================================
	// Output mapping.
	assign rdData         = rdData_q;
	assign midiOut        = midiOut_q;
	assign midiThru       = midiThru_q;
	assign hostTxd        = hostTxd_q;
	assign sceneRecall    = sceneRecall_q;
	assign sceneNum       = sceneNum_q;
	assign paramAdjust    = paramAdjust_q;
	assign ccNum          = ccNum_q;
	assign ccValue        = ccValue_q;
	assign sysexValid     = sysexValid_q;
	assign sysexByte      = sysexByte_q;
	assign bulkValid      = bulkValid_q;
	assign bulkByte       = bulkByte_q;
	assign paramRequest   = paramRequest_q;
	assign bulkRequest    = bulkRequest_q;
	assign requestChannel = reqCh_q;

	// Both directions share one bit time; only setting b runs faster.
	wire [8:0] bitLen = (portSel_q == `PORT_HOST_B) ? HOSTB_CYC : MIDI_CYC;

	// ======================================================================
	// Receiver.
	reg       rxLine_q, rxBusy_q, rxDone_q;
	reg [8:0] rxCnt_q;
	reg [3:0] rxBit_q;
	reg [7:0] rxSh_q;

	// Start is checked again at mid bit, so a glitch does not open a frame.
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rxLine_q <= 1'b1;
			rxBusy_q <= 1'b0;
			rxDone_q <= 1'b0;
			rxCnt_q  <= 9'h000;
			rxBit_q  <= 4'h0;
			rxSh_q   <= 8'h00;
		end else begin
			rxLine_q <= (portSel_q == `PORT_MIDI) ? midiIn : hostRxd;
			rxDone_q <= 1'b0;
			if (!rxBusy_q) begin
				if (!rxLine_q) begin
					rxBusy_q <= 1'b1;
					rxCnt_q  <= bitLen >> 1;
					rxBit_q  <= 4'h0;
				end
			end else if (rxCnt_q != 9'h000) begin
				rxCnt_q <= rxCnt_q - 9'h001;
			end else begin
				rxCnt_q <= bitLen - 9'h001;
				rxBit_q <= rxBit_q + 4'h1;
				if (rxBit_q == 4'h0 && rxLine_q) begin
					rxBusy_q <= 1'b0;
				end else if (rxBit_q >= 4'h1 && rxBit_q <= 4'h8) begin
					rxSh_q <= {rxLine_q, rxSh_q[7:1]};
				end else if (rxBit_q == 4'h9) begin
					rxBusy_q <= 1'b0;
					rxDone_q <= rxLine_q;
				end
			end
		end
	end

	// ======================================================================
	// Parser state and echo decision.
	wire [7:0] rb = rxSh_q;
	wire       rxTake = rxDone_q && rb < `MSG_REALTIME;
	reg  [7:0] st_q, sxSub_q, sxId_q;
	reg        ccIdx_q, sxEcho_q, sxApply_q, sxBulk_q;
	reg  [1:0] sxIdx_q;
	reg        rxPush;

	// Echo copies the incoming byte straight into the send queue.
	always @* begin
		rxPush = 1'b0;
		if (rxTake) begin
			if (rb[7]) begin
				if (rb == `MSG_EOX)
					rxPush = sxEcho_q;
				else if (rb[7:4] == `MSG_PROG)
					rxPush = sw_q[`SW_PC_ECHO];
				else if (rb[7:4] == `MSG_CTRL)
					rxPush = sw_q[`SW_CC_ECHO];
			end else if (st_q[7:4] == `MSG_PROG) begin
				rxPush = sw_q[`SW_PC_ECHO];
			end else if (st_q[7:4] == `MSG_CTRL) begin
				rxPush = sw_q[`SW_CC_ECHO];
			end else if (st_q == `MSG_SYSEX && sxIdx_q == 2'h2) begin
				rxPush = sxEcho_q;
			end
		end
	end

	// ======================================================================
	// Emitter and send queue.
	reg  [7:0] eb_q [0:5];
	reg  [2:0] emLen_q, emIdx_q;
	reg        emBusy_q, emLink_q, echoHdrPend_q;
	reg  [8:0] fifoMem [0:DEPTH-1];
	reg  [FIFO_AW:0] wp_q, rp_q;
	wire [FIFO_AW:0] fifoCnt = wp_q - rp_q;
	wire       fifoFull  = fifoCnt == DEPTH;
	wire       fifoEmpty = fifoCnt == {(FIFO_AW + 1){1'b0}};
	wire       emPush    = emBusy_q && !rxPush && !fifoFull;
	wire [8:0] pushData  = rxPush ? {1'b0, rb} : {emLink_q, eb_q[emIdx_q]};
	wire       push      = (rxPush && !fifoFull) || emPush;

	// Scene scan state.
	reg        scanBusy_q, scanPend_q, scanFound_q;
	reg  [6:0] scanIdx_q, scanScene_q;
	wire [7:0] scanEnt = progMap[scanIdx_q];
	wire [7:0] rxEnt   = progMap[rb[6:0]];
	wire       emFree  = !emBusy_q && !echoHdrPend_q && !scanPend_q;
	wire [7:0] sxIn    = wrData[7:0];
	wire       sxOk    = wrData[`SEND_BULK_BIT] || sw_q[`SW_PM_TX] ||
	                     (wrData[`SEND_ANSWER_BIT] && sw_q[`SW_PM_RX]);
	wire [3:0] sxCh    = wrData[`SEND_ANSWER_BIT] ? reqCh_q : txCh_q;

	// ======================================================================
	// Control: registers, parser, scan and emitter.
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			portSel_q <= `PORT_MIDI;
			txCh_q <= 4'h0;
			rxCh_q <= 4'h0;
			reqCh_q <= 4'h0;
			sw_q <= `SWITCHES_RESET;
			mapPtr_q <= 7'h00;
			initBusy_q <= 1'b1;
			initIdx_q <= 7'h00;
			st_q <= 8'h00;
			sxSub_q <= 8'h00;
			sxId_q <= 8'h00;
			ccIdx_q <= 1'b0;
			sxIdx_q <= 2'h0;
			sxEcho_q <= 1'b0;
			sxApply_q <= 1'b0;
			sxBulk_q <= 1'b0;
			sceneRecall_q <= 1'b0;
			paramAdjust_q <= 1'b0;
			sysexValid_q <= 1'b0;
			bulkValid_q <= 1'b0;
			paramRequest_q <= 1'b0;
			bulkRequest_q <= 1'b0;
			sceneNum_q <= 7'h00;
			ccNum_q <= 7'h00;
			ccValue_q <= 7'h00;
			sysexByte_q <= 8'h00;
			bulkByte_q <= 8'h00;
			for (i = 0; i < 6; i = i + 1)
				eb_q[i] <= 8'h00;
			emLen_q <= 3'h0;
			emIdx_q <= 3'h0;
			emBusy_q <= 1'b0;
			emLink_q <= 1'b0;
			echoHdrPend_q <= 1'b0;
			scanBusy_q <= 1'b0;
			scanPend_q <= 1'b0;
			scanFound_q <= 1'b0;
			scanIdx_q <= 7'h00;
			scanScene_q <= 7'h00;
		end else begin
			sceneRecall_q <= 1'b0;
			paramAdjust_q <= 1'b0;
			sysexValid_q <= 1'b0;
			bulkValid_q <= 1'b0;
			paramRequest_q <= 1'b0;
			bulkRequest_q <= 1'b0;
			// The map reloads its default table after reset or on command.
			if (initBusy_q) begin
				initIdx_q <= initIdx_q + 7'h01;
				if (initIdx_q == 7'h7f)
					initBusy_q <= 1'b0;
			end
			// Register writes; sends made while busy are dropped.
			if (wrEn) begin
				case (addr)
					`REG_CONFIG: begin
						portSel_q <= wrData[1:0];
						txCh_q <= wrData[7:4];
						rxCh_q <= wrData[11:8];
					end
					`REG_SWITCHES: sw_q <= wrData[11:0];
					`REG_MAP_PTR: begin
						mapPtr_q <= wrData[6:0];
						if (wrData[`MAP_INIT_BIT]) begin
							initBusy_q <= 1'b1;
							initIdx_q <= 7'h00;
						end
					end
					`REG_SCENE_SEND: if (!scanBusy_q && !scanPend_q && !initBusy_q) begin
						scanBusy_q <= 1'b1;
						scanIdx_q <= 7'h00;
						scanScene_q <= wrData[6:0];
					end
					`REG_CC_SEND: if (emFree && sw_q[`SW_CC_TX]) begin
						eb_q[0] <= {`MSG_CTRL, txCh_q};
						eb_q[1] <= {1'b0, wrData[14:8]};
						eb_q[2] <= {1'b0, wrData[6:0]};
						emLen_q <= 3'h3;
						emIdx_q <= 3'h0;
						emLink_q <= 1'b0;
						emBusy_q <= 1'b1;
					end
					`REG_SYSEX_SEND: if (emFree && sxOk) begin
						// Bulk dumps pass whatever the switches say.
						eb_q[0] <= wrData[`SEND_SUBST_BIT] ? {sxIn[7:4], sxCh} : sxIn;
						emLen_q <= 3'h1;
						emIdx_q <= 3'h0;
						emLink_q <= 1'b0;
						emBusy_q <= 1'b1;
					end
					default: ;
				endcase
			end
			// Lowest matching program index wins because the scan counts up.
			if (scanBusy_q) begin
				if (scanEnt[7] && scanEnt[6:0] == scanScene_q) begin
					scanBusy_q <= 1'b0;
					scanPend_q <= 1'b1;
					scanFound_q <= 1'b1;
				end else if (scanIdx_q == 7'h7f) begin
					scanBusy_q <= 1'b0;
					scanPend_q <= 1'b1;
					scanFound_q <= 1'b0;
				end else begin
					scanIdx_q <= scanIdx_q + 7'h01;
				end
			end
			// Emitter: echo headers first, then scene results.
			if (emPush) begin
				emIdx_q <= emIdx_q + 3'h1;
				if (emIdx_q == emLen_q - 3'h1)
					emBusy_q <= 1'b0;
			end else if (!emBusy_q && echoHdrPend_q) begin
				echoHdrPend_q <= 1'b0;
				eb_q[0] <= `MSG_SYSEX;
				eb_q[1] <= sxId_q;
				eb_q[2] <= sxSub_q;
				emLen_q <= 3'h3;
				emIdx_q <= 3'h0;
				emLink_q <= 1'b0;
				emBusy_q <= 1'b1;
			end else if (!emBusy_q && scanPend_q) begin
				scanPend_q <= 1'b0;
				emIdx_q <= 3'h0;
				if (scanFound_q) begin
					eb_q[0] <= {`MSG_PROG, txCh_q};
					eb_q[1] <= {1'b0, scanIdx_q};
					emLen_q <= 3'h2;
					emLink_q <= 1'b1;
					emBusy_q <= sw_q[`SW_PC_TX];
				end else begin
					eb_q[0] <= `MSG_SYSEX;
					eb_q[1] <= MAKER_ID;
					eb_q[2] <= {`SUB_PARAM, txCh_q};
					eb_q[3] <= `SCENE_RECALL_CODE;
					eb_q[4] <= {1'b0, scanScene_q};
					eb_q[5] <= `MSG_EOX;
					emLen_q <= 3'h6;
					emLink_q <= 1'b0;
					emBusy_q <= 1'b1;
				end
			end
			// Parser: a status byte below the real-time range restarts every message; real-time bytes never reach it.
			if (rxTake) begin
				if (rb[7]) begin
					if (rb == `MSG_EOX) begin
						sysexValid_q <= sxApply_q;
						sysexByte_q <= rb;
						bulkValid_q <= sxBulk_q;
						bulkByte_q <= rb;
					end
					st_q <= rb;
					ccIdx_q <= 1'b0;
					sxIdx_q <= 2'h0;
					sxEcho_q <= 1'b0;
					sxApply_q <= 1'b0;
					sxBulk_q <= 1'b0;
				end else if (st_q[7:4] == `MSG_PROG) begin
					if (sw_q[`SW_PC_RX] && chanOk(sw_q[`SW_PC_OMNI], st_q[3:0], rxCh_q) && rxEnt[7]) begin
						sceneRecall_q <= 1'b1;
						sceneNum_q <= rxEnt[6:0];
					end
				end else if (st_q[7:4] == `MSG_CTRL) begin
					ccIdx_q <= ~ccIdx_q;
					if (!ccIdx_q)
						ccNum_q <= rb[6:0];
					else if (sw_q[`SW_CC_RX] && chanOk(sw_q[`SW_CC_OMNI], st_q[3:0], rxCh_q)) begin
						paramAdjust_q <= 1'b1;
						ccValue_q <= rb[6:0];
					end
				end else if (st_q == `MSG_SYSEX) begin
					if (sxIdx_q == 2'h0) begin
						sxId_q <= rb;
						sxIdx_q <= 2'h1;
					end else if (sxIdx_q == 2'h1) begin
						sxIdx_q <= 2'h2;
						sxSub_q <= rb;
						case (rb[7:4])
							`SUB_PARAM: begin
								sxEcho_q <= sw_q[`SW_PM_ECHO];
								echoHdrPend_q <= sw_q[`SW_PM_ECHO];
								sxApply_q <= sw_q[`SW_PM_RX];
							end
							`SUB_PARAM_REQ: if (sw_q[`SW_PM_RX]) begin
								paramRequest_q <= 1'b1;
								reqCh_q <= rb[3:0];
							end
							`SUB_BULK_REQ: if (sw_q[`SW_BULK_EN]) begin
								bulkRequest_q <= 1'b1;
								reqCh_q <= rb[3:0];
							end
							`SUB_BULK_DUMP: sxBulk_q <= sw_q[`SW_BULK_EN];
							default: ;
						endcase
					end else begin
						sysexValid_q <= sxApply_q;
						sysexByte_q <= rb;
						bulkValid_q <= sxBulk_q;
						bulkByte_q <= rb;
					end
				end
			end
		end
	end

	// ======================================================================
	// Scene map storage, written by the init sweep or by software.
	wire       mapWe = initBusy_q || (wrEn && addr == `REG_MAP_DATA);
	wire [6:0] mapWa = initBusy_q ? initIdx_q : mapPtr_q;
	wire [7:0] mapWd = initBusy_q ? {initIdx_q < `MAP_INIT_COUNT, initIdx_q + 7'h01} : wrData[7:0];

	// Program index p defaults to scene p+1 for the first 99 entries.
	always @(posedge ref_clk) begin
		if (mapWe)
			progMap[mapWa] <= mapWd;
	end

	// ======================================================================
	// Send queue and transmitter.
	reg       txBusy_q, txLink_q;
	reg [8:0] txCnt_q;
	reg [3:0] txBit_q;
	reg [9:0] txSh_q;
	// The link copy only goes out when both ports share one bit rate.
	wire      linkOk = txLink_q && portSel_q != `PORT_HOST_B;

	always @(posedge ref_clk) begin
		if (push)
			fifoMem[wp_q[FIFO_AW-1:0]] <= pushData;
	end

	// Frame is start, eight data bits LSB first, stop.
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wp_q <= {(FIFO_AW + 1){1'b0}};
			rp_q <= {(FIFO_AW + 1){1'b0}};
			txBusy_q <= 1'b0;
			txLink_q <= 1'b0;
			txCnt_q <= 9'h000;
			txBit_q <= 4'h0;
			txSh_q <= 10'h3ff;
			midiOut_q <= 1'b1;
			hostTxd_q <= 1'b1;
			midiThru_q <= 1'b1;
		end else begin
			midiThru_q <= midiIn;
			if (push)
				wp_q <= wp_q + {{FIFO_AW{1'b0}}, 1'b1};
			if (!txBusy_q) begin
				if (!fifoEmpty) begin
					txSh_q <= {1'b1, fifoMem[rp_q[FIFO_AW-1:0]][7:0], 1'b0};
					txLink_q <= fifoMem[rp_q[FIFO_AW-1:0]][8];
					rp_q <= rp_q + {{FIFO_AW{1'b0}}, 1'b1};
					txBusy_q <= 1'b1;
					txCnt_q <= bitLen - 9'h001;
					txBit_q <= 4'h0;
				end
			end else if (txCnt_q != 9'h000) begin
				txCnt_q <= txCnt_q - 9'h001;
			end else begin
				txCnt_q <= bitLen - 9'h001;
				txSh_q <= {1'b1, txSh_q[9:1]};
				txBit_q <= txBit_q + 4'h1;
				if (txBit_q == 4'h9)
					txBusy_q <= 1'b0;
			end
			midiOut_q <= (portSel_q == `PORT_MIDI || linkOk) ? txSh_q[0] : 1'b1;
			hostTxd_q <= (portSel_q != `PORT_MIDI || linkOk) ? txSh_q[0] : 1'b1;
		end
	end

	// ======================================================================
	// Read port: data stands only in the cycle after the strobe.
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rdEn_q <= 1'b0;
			rdData_q <= 16'h0000;
		end else begin
			rdEn_q <= rdEn;
			rdData_q <= 16'h0000;
			if (rdEn) begin
				case (addr)
					`REG_CONFIG:    rdData_q <= {4'h0, rxCh_q, txCh_q, 2'h0, portSel_q};
					`REG_SWITCHES:  rdData_q <= {4'h0, sw_q};
					`REG_MAP_PTR:   rdData_q <= {9'h000, mapPtr_q};
					`REG_MAP_DATA:  rdData_q <= {8'h00, progMap[mapPtr_q]};
					`REG_STATUS:    rdData_q <= {reqCh_q, 2'h0, {(5 - FIFO_AW){1'b0}}, fifoCnt,
					                              initBusy_q, scanBusy_q | scanPend_q, emBusy_q,
					                              portSel_q == `PORT_MIDI};
					default:        rdData_q <= 16'h0000;
				endcase
			end
		end
	end
endmodule

// *** bench/midi_router_props.sv ***
`include "midi_router_regs.vh"
// ==========
// Checker on the router pins.
module midi_router_props (
	// Clock and reset.
	input wire        ref_clk,
	input wire        rst,
	// Register port.
	input wire        rdEn,
	input wire [15:0] rdData,
	// Serial pins.
	input wire        midiIn,
	input wire        midiOut,
	input wire        midiThru,
	input wire        hostTxd,
	// Mixer side.
	input wire        sceneRecall,
	input wire [6:0]  sceneNum,
	input wire        paramAdjust,
	input wire [6:0]  ccNum,
	input wire [6:0]  ccValue
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int BIT = `MIDI_BIT_CYC;
	logic [12:0] lowOut;
	logic [12:0] lowHost;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Low run length of each transmit line; a low run must be whole bits, never past the stop bit.
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			lowOut  <= 13'h0000;
			lowHost <= 13'h0000;
		end else begin
			lowOut  <= midiOut ? 13'h0000 : lowOut + 13'h0001;
			lowHost <= hostTxd ? 13'h0000 : lowHost + 13'h0001;
		end
	end
	chk_thru_copy: assert property (midiThru == $past(midiIn))
		else $error("Thru line does not follow the input.");
	chk_out_bits: assert property ($rose(midiOut) |-> lowOut % BIT == 0)
		else $error("Output low run is not whole bits.");
	chk_host_bits: assert property ($rose(hostTxd) |-> lowHost % BIT == 0)
		else $error("Host low run is not whole bits.");
	chk_out_stop: assert property (lowOut <= 9 * BIT)
		else $error("Output frame lacks its stop bit.");
	chk_host_stop: assert property (lowHost <= 9 * BIT)
		else $error("Host frame lacks its stop bit.");
	chk_recall_hold: assert property (sceneRecall |=> $stable(sceneNum)[*8])
		else $error("Scene number moved after a recall.");
	chk_cc_hold: assert property (paramAdjust |=> $stable({ccNum, ccValue})[*8])
		else $error("Control pair moved after an adjust.");
	chk_after_stop: assert property ((sceneRecall || paramAdjust) |-> $past(midiIn, 2) && midiIn)
		else $error("Message acted on outside a stop bit.");
	chk_rd_window: assert property (!$past(rdEn) |-> rdData == 16'h0000)
		else $error("Read data outside its cycle.");
	// Main scenarios.
	cover property (sceneRecall);
	cover property (paramAdjust);
	cover property ($fell(hostTxd));
endmodule

// *** bench/midi_partner.sv ***
// ==========
// Far-side MIDI device: sends frames into the router and decodes its output line.
module midi_partner #(
	parameter int BIT = 320
)(
	// Bench side.
	input  wire logic  clk,
	output logic       rxValid,
	output logic [7:0] rxByte,
	// Serial lines.
	output logic       txLine,
	input  wire logic  rxLine
);
	timeunit 1ns;
	timeprecision 1ns;
	// The line idles high between frames.
	initial txLine = 1'b1;
	// Start bit, eight data bits LSB first, stop bit, one bit time each.
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			txLine <= f[i];
			repeat (BIT - 1) @(posedge clk);
		end
	endtask
	// Receiver samples mid bit; a byte with a low stop bit is dropped, so the bench times out.
	initial begin
		rxValid = 1'b0;
		rxByte  = 8'h00;
		forever begin
			@(posedge clk);
			rxValid <= 1'b0;
			if (rxLine === 1'b0) begin
				repeat (BIT / 2) @(posedge clk);
				for (int i = 0; i < 8; i++) begin
					repeat (BIT) @(posedge clk);
					rxByte[i] <= rxLine;
				end
				repeat (BIT) @(posedge clk);
				rxValid <= (rxLine === 1'b1);
			end
		end
	end
endmodule

// *** bench/midi_message_filter_router_tb_top.sv ***
`include "midi_router_regs.vh"
// ==========
// Bench top: register port driver, result queues and the watcher.
module midi_message_filter_router_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] MAKER = 8'h5a; // Arbitrary value.
	logic        ref_clk;
	logic        rst;
	logic [3:0]  addr;
	logic [15:0] wrData;
	logic        wrEn;
	logic        rdEn;
	logic        rdPend;
	wire  [15:0] rdData;
	wire         midiIn, midiOut, midiThru, hostTxd, sceneRecall, paramAdjust, rxValid;
	wire  [6:0]  sceneNum, ccNum, ccValue;
	wire  [7:0]  rxByte;
	wire         sysexValid, bulkValid, paramRequest, bulkRequest;
	wire  [7:0]  sysexByte, bulkByte;
	wire  [3:0]  requestChannel;
	logic        hostRxd;
	logic [15:0] rdQ[$], expQ[$], sceneQ[$], ccQ[$], reqQ[$], sxQ[$];
	logic [7:0]  sx[$];
	logic [3:0]  rxCh, txCh, offCh;
	int          n_errors, total_checks, seedVal;

	midi_message_filter_router #(.FIFO_AW(4), .MAKER_ID(MAKER)) dut_u (
		.ref_clk(ref_clk), .rst(rst), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
		.midiIn(midiIn), .midiOut(midiOut), .midiThru(midiThru), .hostRxd(hostRxd), .hostTxd(hostTxd),
		.sceneRecall(sceneRecall), .sceneNum(sceneNum), .paramAdjust(paramAdjust), .ccNum(ccNum), .ccValue(ccValue),
		.sysexValid(sysexValid), .sysexByte(sysexByte), .bulkValid(bulkValid), .bulkByte(bulkByte),
		.paramRequest(paramRequest), .bulkRequest(bulkRequest), .requestChannel(requestChannel));
	midi_partner #(.BIT(`MIDI_BIT_CYC)) partner_u (
		.clk(ref_clk), .rxValid(rxValid), .rxByte(rxByte), .txLine(midiIn), .rxLine(midiOut));

	// 10 MHz clock.
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// An unexpected result meets an unknown note and so always mismatches.
	task automatic take(ref logic [15:0] q[$], input logic [15:0] g, input string nm);
		logic [15:0] e;
		e = (q.size() > 0) ? q.pop_front() : 16'hxxxx;
		chk(nm, e, g);
	endtask
	task tally_and_finish();
		$display("Checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		addr   <= a;
		wrData <= d;
		wrEn   <= 1'b1;
		@(posedge ref_clk);
		wrEn   <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge ref_clk);
		addr <= a;
		rdEn <= 1'b1;
		rdQ.push_back(e);
		@(posedge ref_clk);
		rdEn <= 1'b0;
	endtask
	task send(input logic [7:0] a, input logic [7:0] b);
		partner_u.send_byte(a);
		partner_u.send_byte(b);
	endtask
	// Bounded wait until every noted result has been seen.
	task drain();
		int k;
		k = 0;
		while (expQ.size() + sceneQ.size() + ccQ.size() + rdQ.size() + reqQ.size() + sxQ.size() != 0 && k < 40000) begin
			@(posedge ref_clk);
			k++;
		end
		if (k >= 40000) begin
			n_errors++;
			$display("Error drain expected 0 seen %0d", expQ.size() + sceneQ.size() + ccQ.size());
			tally_and_finish();
		end
	endtask

	// Watcher: each result takes the oldest note of its kind.
	always @(posedge ref_clk) begin
		rdPend <= rdEn;
		if (rdPend)
			take(rdQ, rdData, "rdData");
		if (rxValid)
			take(expQ, {8'h00, rxByte}, "midiOut");
		if (sceneRecall)
			take(sceneQ, {9'h000, sceneNum}, "sceneNum");
		if (paramAdjust)
			take(ccQ, {2'h0, ccNum, ccValue}, "ccPair");
		// Requests carry their kind and channel; no scenario expects applied or bulk bytes.
		if (paramRequest || bulkRequest)
			take(reqQ, {11'h000, bulkRequest, requestChannel}, "request");
		if (sysexValid || bulkValid)
			take(sxQ, {6'h00, sysexValid, bulkValid, sysexByte}, "sysexOut");
	end

	// Main sequence.
	initial begin
		rst = 1'b1;
		addr = 4'h0;
		wrData = 16'h0000;
		wrEn = 1'b0;
		rdEn = 1'b0;
		hostRxd = 1'b1;
		n_errors = 0;
		total_checks = 0;
		seedVal = $urandom(32'h8369);
		rxCh = 4'($urandom);
		txCh = 4'($urandom);
		offCh = rxCh ^ 4'h1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (130) @(posedge ref_clk);
		// Reset values, an unmapped read, and the link port moving with the port setting.
		rd(`REG_SWITCHES, 16'h0a03);
		rd(`REG_CONFIG, 16'h0000);
		rd(4'hf, 16'h0000);
		rd(`REG_STATUS, 16'h0001);
		wr(`REG_CONFIG, {14'h0000, `PORT_HOST_A});
		rd(`REG_STATUS, 16'h0000);
		wr(`REG_CONFIG, {4'h0, rxCh, txCh, 2'h0, `PORT_MIDI});
		// Receive channel accepted, another channel ignored while omni is off.
		sceneQ.push_back(16'h0006);
		send({`MSG_PROG, rxCh}, 8'h05);
		send({`MSG_PROG, offCh}, 8'h07);
		drain();
		// Omni and echo on: the off-channel change is acted on and forwarded.
		wr(`REG_SWITCHES, 16'h0a2f);
		sceneQ.push_back(16'h000a);
		expQ.push_back({8'h00, `MSG_PROG, offCh});
		expQ.push_back(16'h0009);
		send({`MSG_PROG, offCh}, 8'h09);
		drain();
		// Control change on the receive channel only.
		ccQ.push_back({2'h0, 7'h0a, 7'h40});
		send({`MSG_CTRL, rxCh}, 8'h0a);
		partner_u.send_byte(8'h40);
		send({`MSG_CTRL, offCh}, 8'h0b);
		partner_u.send_byte(8'h41);
		drain();
		// Scene recall sends the lowest mapped program on the transmit channel.
		expQ.push_back({8'h00, `MSG_PROG, txCh});
		expQ.push_back(16'h0005);
		wr(`REG_SCENE_SEND, 16'h0006);
		drain();
		wr(`REG_MAP_PTR, 16'h0004);
		wr(`REG_MAP_DATA, 16'h0089);
		expQ.push_back({8'h00, `MSG_PROG, txCh});
		expQ.push_back(16'h0004);
		wr(`REG_SCENE_SEND, 16'h0009);
		drain();
		// Transmit switch off: nothing leaves, the emitter stays idle.
		wr(`REG_SWITCHES, 16'h0a2e);
		wr(`REG_SCENE_SEND, 16'h0006);
		repeat (16) @(posedge ref_clk);
		rd(`REG_STATUS, 16'h0001);
		// An unmapped scene sends the system exclusive recall instead.
		sx = '{`MSG_SYSEX, MAKER, {4'h1, txCh}, `SCENE_RECALL_CODE, 8'h64, `MSG_EOX};
		foreach (sx[i]) expQ.push_back({8'h00, sx[i]});
		wr(`REG_SCENE_SEND, 16'h0064);
		drain();
		// A parameter request; the answer uses its channel even with transmit off, a plain send is dropped.
		reqQ.push_back({12'h000, ~txCh});
		partner_u.send_byte(`MSG_SYSEX);
		send(MAKER, {`SUB_PARAM_REQ, ~txCh});
		drain();
		wr(`REG_SYSEX_SEND, 16'h0010);
		expQ.push_back({8'h00, 4'h1, ~txCh});
		wr(`REG_SYSEX_SEND, 16'h0310);
		drain();
		tally_and_finish();
	end
endmodule

bind midi_message_filter_router midi_router_props props_u (.ref_clk(ref_clk), .rst(rst), .rdEn(rdEn), .rdData(rdData),
	.midiIn(midiIn), .midiOut(midiOut), .midiThru(midiThru), .hostTxd(hostTxd), .sceneRecall(sceneRecall),
	.sceneNum(sceneNum), .paramAdjust(paramAdjust), .ccNum(ccNum), .ccValue(ccValue));
